/* File: core/camd_defs.svh */
// Notes on behaviour
// - The decoder knows seventeen operand addressing modes in the inherent, immediate, direct, indexed, indirect, relative and bit groups.
// - Direct and indexed long forms reach the whole 64 Kbyte space and cost one more byte than short forms; indirect long and short are both three bytes.
// - Short forms other than indexed short stay in page zero, 0000h to 00FFh; of these only direct short has a shorter encoding.
// - Read-modify-write operations on memory accept only short addressing forms.
// - An inherent instruction is one byte and fetches nothing after the opcode.
// - An immediate instruction is two bytes, opcode then literal operand.
// - Direct modes take the operand address from the instruction and access memory there.
// - Direct short fetches one address byte, giving an operand in 00 to FF.
// - Direct long fetches a two-byte address word reaching the full 64 Kbyte space.
// - Indexed with no offset adds no byte with the first index register and one with the second.
// - A relative target is the signed offset added to a program counter already at the next instruction.
// - The wait-for-interrupt instruction is a one-byte inherent op that holds the core waiting until an interrupt.
// - The halt instruction is a one-byte inherent op that stops the oscillator in the lowest-power state.
// - Push and pop are one-byte inherent ops that move a register to or from the stack and adjust the pointer.
// - Indexed short adds an index register and a one-byte offset unsigned, giving 00 to 1FE.
`ifndef CAMD_DEFS_SVH
`define CAMD_DEFS_SVH
`define CAMD_MODE_MSB   7
`define CAMD_MODE_LSB   3
`define CAMD_RMW_BIT    2
`define CAMD_MODE_LAST  5'h10
`define CAMD_OP_WAIT    3'h1
`define CAMD_OP_HALT    3'h2
`define CAMD_OP_PUSH    3'h3
`define CAMD_OP_POP     3'h4
`define CAMD_PAGE0_HI   8'h00
`define CAMD_SP_RESET   8'hFF
`define CAMD_BYTE_RESET 8'h00
`define CAMD_ADDR_RESET 16'h0000
`endif

/* File: core/camd_pkg.sv */
package camd_pkg;
  typedef enum logic [4:0] {
    CAMD_INH      = 5'h00,
    CAMD_IMM      = 5'h01,
    CAMD_DIR_S    = 5'h02,
    CAMD_DIR_L    = 5'h03,
    CAMD_IDX_0    = 5'h04,
    CAMD_IDX_S    = 5'h05,
    CAMD_IDX_L    = 5'h06,
    CAMD_IND_S    = 5'h07,
    CAMD_IND_L    = 5'h08,
    CAMD_INDIDX_S = 5'h09,
    CAMD_INDIDX_L = 5'h0A,
    CAMD_REL_D    = 5'h0B,
    CAMD_REL_I    = 5'h0C,
    CAMD_BIT_D    = 5'h0D,
    CAMD_BIT_I    = 5'h0E,
    CAMD_BIT_DR   = 5'h0F,
    CAMD_BIT_IR   = 5'h10
  } camd_mode_t;

  typedef enum logic [1:0] {
    CAMD_IDLE  = 2'b00,
    CAMD_FETCH = 2'b01,
    CAMD_DONE  = 2'b11
  } camd_state_t;
endpackage : camd_pkg

/* File: core/camd_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
`include "camd_defs.svh"

module camd_decoder
  import camd_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // opcode from fetch
  input  wire logic        op_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic        use_y,
  input  wire logic [15:0] pc_next,
  input  wire logic [7:0]  idx_val,
  // operand bytes from fetch
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  // wake from low power
  input  wire logic        irq_pend,
  // decode results
  output var  logic        op_ready_q,
  output var  logic [1:0]  fetch_cnt_q,
  output var  logic        dec_valid_q,
  output var  camd_mode_t  dec_mode_q,
  output var  logic [1:0]  op_len_q,
  output var  logic [15:0] ea_q,
  output var  logic [7:0]  operand_q,
  output var  logic        page0_q,
  output var  logic        illegal_q,
  // power and stack
  output var  logic        wait_q,
  output var  logic        halt_q,
  output var  logic [7:0]  sp_q
);

  camd_state_t state_q, state_d;
  camd_mode_t  mode_q;
  logic        y_q, rmw_q, bad_q;
  logic [2:0]  sub_q;
  logic [15:0] pc_q;
  logic [7:0]  idx_q, b0_q, b1_q;
  logic [1:0]  pos_q, need_q;

  // opcode decode: mode class in the top bits, operation in the low bits
  wire [4:0]  mode_w   = opcode[`CAMD_MODE_MSB:`CAMD_MODE_LSB];
  wire        legal_w  = mode_w <= `CAMD_MODE_LAST;
  wire        take_w   = op_valid && op_ready_q;

  function automatic logic [1:0] len_of(input logic [4:0] m, input logic y);
    case (m)
      CAMD_INH:                           len_of = 2'd0;
      CAMD_IMM, CAMD_DIR_S, CAMD_IDX_S:   len_of = 2'd1;
      CAMD_REL_D, CAMD_BIT_D:             len_of = 2'd1;
      CAMD_IDX_0:                         len_of = {1'b0, y};
      CAMD_BIT_IR:                        len_of = 2'd3;
      default:                            len_of = 2'd2;
    endcase
  endfunction

  // indirect forms spend one of their bytes on a prebyte ahead of the opcode
  function automatic logic pre_of(input logic [4:0] m, input logic y);
    case (m)
      CAMD_IND_S, CAMD_IND_L, CAMD_INDIDX_S, CAMD_INDIDX_L,
      CAMD_REL_I, CAMD_BIT_I, CAMD_BIT_IR: pre_of = 1'b1;
      CAMD_IDX_0:                          pre_of = y;
      default:                             pre_of = 1'b0;
    endcase
  endfunction

  wire [1:0] len_w   = legal_w ? len_of(mode_w, use_y) : 2'd0;
  wire [1:0] fetch_w = legal_w ? len_w - {1'b0, pre_of(mode_w, use_y)} : 2'd0;
  wire       last_w  = byte_valid && (pos_q == need_q - 2'd1);

  wire long_w  = (mode_q == CAMD_DIR_L) || (mode_q == CAMD_IDX_L) ||
                 (mode_q == CAMD_IND_L) || (mode_q == CAMD_INDIDX_L);
  wire inh_w   = (mode_q == CAMD_INH) && !bad_q;
  wire rmw_bad = rmw_q && long_w && (mode_q != CAMD_INH);

  // effective address forming
  wire [15:0] word_w   = {b0_q, b1_q};
  wire [8:0]  idxs_w   = {1'b0, idx_q} + {1'b0, b0_q};
  wire [15:0] idxl_w   = word_w + {8'h00, idx_q};
  // bit direct carries only its address byte, so b1 would be stale there
  wire [7:0]  off_w    = (mode_q == CAMD_BIT_DR) ? b1_q : b0_q;
  wire [7:0]  roff_w   = (mode_q == CAMD_BIT_DR || mode_q == CAMD_BIT_IR) ? b1_q : b0_q;
  wire [15:0] rel_w    = pc_q + {{8{roff_w[7]}}, roff_w};
  logic [15:0] ea_w;
  always_comb begin
    unique case (mode_q)
      CAMD_DIR_S, CAMD_BIT_D:         ea_w = {`CAMD_PAGE0_HI, b0_q};
      CAMD_DIR_L:                     ea_w = word_w;
      CAMD_IDX_0:                     ea_w = {`CAMD_PAGE0_HI, idx_q};
      CAMD_IDX_S:                     ea_w = {7'h00, idxs_w};
      CAMD_IDX_L:                     ea_w = idxl_w;
      CAMD_REL_D, CAMD_BIT_DR:        ea_w = rel_w;
      CAMD_IND_S, CAMD_IND_L, CAMD_INDIDX_S, CAMD_INDIDX_L,
      CAMD_REL_I, CAMD_BIT_I, CAMD_BIT_IR:
                                      ea_w = {`CAMD_PAGE0_HI, b0_q};
      default:                        ea_w = `CAMD_ADDR_RESET;
    endcase
  end
  wire page0_w = (ea_w[15:8] == `CAMD_PAGE0_HI) && !long_w;
  wire [7:0] lit_w = (mode_q == CAMD_IMM) ? b0_q : off_w;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CAMD_IDLE:  if (take_w) state_d = (fetch_w == 2'd0) ? CAMD_DONE : CAMD_FETCH;
      CAMD_FETCH: if (last_w) state_d = CAMD_DONE;
      CAMD_DONE:  state_d = CAMD_IDLE;
      default:    state_d = CAMD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= CAMD_IDLE;
      mode_q  <= CAMD_INH;
      y_q     <= 1'b0;
      rmw_q   <= 1'b0;
      bad_q   <= 1'b0;
      sub_q   <= 3'h0;
      pc_q    <= `CAMD_ADDR_RESET;
      idx_q   <= `CAMD_BYTE_RESET;
      need_q  <= 2'd0;
    end else begin
      state_q <= state_d;
      if (take_w) begin
        mode_q <= legal_w ? camd_mode_t'(mode_w) : CAMD_INH;
        y_q    <= use_y;
        rmw_q  <= opcode[`CAMD_RMW_BIT];
        bad_q  <= !legal_w;
        sub_q  <= opcode[2:0];
        pc_q   <= pc_next;
        idx_q  <= idx_val;
        need_q <= fetch_w;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos_q <= 2'd0;
      b0_q  <= `CAMD_BYTE_RESET;
      b1_q  <= `CAMD_BYTE_RESET;
    end else if (take_w) begin
      pos_q <= 2'd0;
    end else if (state_q == CAMD_FETCH && byte_valid) begin
      pos_q <= pos_q + 2'd1;
      if (pos_q == 2'd0) b0_q <= byte_data;
      if (pos_q == 2'd1) b1_q <= byte_data;
    end
  end

  wire done_w = state_q == CAMD_DONE;
  wire go_wait_w = done_w && inh_w && sub_q == `CAMD_OP_WAIT;
  wire go_halt_w = done_w && inh_w && sub_q == `CAMD_OP_HALT;
  wire push_w    = done_w && inh_w && sub_q == `CAMD_OP_PUSH;
  wire pop_w     = done_w && inh_w && sub_q == `CAMD_OP_POP;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dec_valid_q <= 1'b0;
      dec_mode_q  <= CAMD_INH;
      op_len_q    <= 2'd0;
      fetch_cnt_q <= 2'd0;
      ea_q        <= `CAMD_ADDR_RESET;
      operand_q   <= `CAMD_BYTE_RESET;
      page0_q     <= 1'b0;
      illegal_q   <= 1'b0;
    end else begin
      dec_valid_q <= done_w;
      if (take_w) fetch_cnt_q <= fetch_w;
      if (done_w) begin
        dec_mode_q <= mode_q;
        op_len_q   <= bad_q ? 2'd0 : len_of(mode_q, y_q);
        ea_q       <= ea_w;
        operand_q  <= lit_w;
        page0_q    <= page0_w;
        illegal_q  <= bad_q || rmw_bad;
      end
    end
  end

  // a fresh wait or halt wins over a wake in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_q     <= 1'b0;
      halt_q     <= 1'b0;
      sp_q       <= `CAMD_SP_RESET;
      op_ready_q <= 1'b0;
    end else begin
      wait_q     <= go_wait_w || (wait_q && !irq_pend);
      halt_q     <= go_halt_w || (halt_q && !irq_pend);
      if (push_w) sp_q <= sp_q - 8'h01;
      else if (pop_w) sp_q <= sp_q + 8'h01;
      op_ready_q <= (state_d == CAMD_IDLE) && !go_wait_w && !go_halt_w &&
                    !((wait_q || halt_q) && !irq_pend);
    end
  end

  inh_len_a: assert property (@(posedge clk) disable iff (!rstn)
    dec_valid_q && dec_mode_q == CAMD_INH |-> op_len_q == 2'd0)
    else $error("inherent length not zero");

  imm_len_a: assert property (@(posedge clk) disable iff (!rstn)
    dec_valid_q && dec_mode_q == CAMD_IMM && !illegal_q |-> op_len_q == 2'd1 && operand_q == b0_q)
    else $error("immediate length or literal wrong");

  dir_short_a: assert property (@(posedge clk) disable iff (!rstn)
    dec_valid_q && dec_mode_q == CAMD_DIR_S |-> ea_q[15:8] == 8'h00 && page0_q && op_len_q == 2'd1)
    else $error("direct short outside page zero");

  dir_long_a: assert property (@(posedge clk) disable iff (!rstn)
    dec_valid_q && dec_mode_q == CAMD_DIR_L |-> op_len_q == 2'd2 && ea_q == {b0_q, b1_q} && !page0_q)
    else $error("direct long address wrong");

  idx_none_a: assert property (@(posedge clk) disable iff (!rstn)
    dec_valid_q && dec_mode_q == CAMD_IDX_0 |-> op_len_q == {1'b0, y_q})
    else $error("no-offset indexed length wrong");

  rel_target_a: assert property (@(posedge clk) disable iff (!rstn)
    dec_valid_q && dec_mode_q == CAMD_REL_D |-> ea_q == pc_q + {{8{b0_q[7]}}, b0_q})
    else $error("relative target wrong");

  rmw_long_a: assert property (@(posedge clk) disable iff (!rstn)
    dec_valid_q && rmw_q && long_w |-> illegal_q)
    else $error("long form accepted for read-modify-write");

  wait_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(wait_q) |-> $past(done_w) && $past(sub_q) == `CAMD_OP_WAIT && !op_ready_q)
    else $error("wait entered without wait op");

  halt_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    halt_q && !irq_pend |=> halt_q && !op_ready_q)
    else $error("halt left without wake");

  stack_adj_a: assert property (@(posedge clk) disable iff (!rstn)
    push_w |=> sp_q == $past(sp_q) - 8'h01)
    else $error("push did not lower stack pointer");

  no_fetch_a: assert property (@(posedge clk) disable iff (!rstn)
    take_w && fetch_w == 2'd0 |-> ##2 dec_valid_q)
    else $error("zero-fetch op not reported in two cycles");

endmodule : camd_decoder
`default_nettype wire

/* File: bench/camd_fetch_model.sv */
`timescale 1ns/10ps
`default_nettype none
module camd_fetch_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // decoder handshake
  input  wire logic       op_valid,
  input  wire logic       op_ready_q,
  input  wire logic [1:0] fetch_cnt_q,
  // bytes to serve, pacing
  input  wire logic [7:0] b0,
  input  wire logic [7:0] b1,
  input  wire logic       slow,
  output var  logic       byte_valid,
  output var  logic [7:0] byte_data
);
  initial begin
    byte_valid = 1'b0;
    byte_data  = 8'h00;
    forever begin
      @(posedge clk);
      if (rstn && op_valid && op_ready_q) begin
        @(posedge clk);
        // serve exactly the count asked
        for (int i = 0; i < fetch_cnt_q; i++) begin
          if (slow) begin
            byte_valid <= 1'b0;
            byte_data  <= ~byte_data;
            @(posedge clk);
          end
          // high byte of a word first
          byte_valid <= 1'b1;
          byte_data  <= (i == 0) ? b0 : b1;
          @(posedge clk);
        end
        // released bus must not keep a stale byte
        byte_valid <= 1'b0;
        byte_data  <= ~byte_data;
      end
    end
  end
endmodule : camd_fetch_model
`default_nettype wire

/* File: bench/camd_decoder_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module camd_decoder_tb
  import camd_pkg::*;
;
  logic        clk, rstn, op_valid, use_y, byte_valid, irq_pend, slow;
  logic [7:0]  opcode, idx_val, byte_data, b0, b1, operand_q, sp_q;
  logic [15:0] pc_next, ea_q;
  logic        op_ready_q, dec_valid_q, page0_q, illegal_q, wait_q, halt_q;
  logic [1:0]  fetch_cnt_q, op_len_q;
  camd_mode_t  dec_mode_q;
  int          err_total, n_checks;
  // two bits per mode, mode 0 lowest
  logic [33:0] len_pk = 34'h3_a66a_a494;
  logic [33:0] cnt_pk = 34'h2_9555_6494;

  camd_decoder i_dut (.clk, .rstn, .op_valid, .opcode, .use_y, .pc_next, .idx_val, .byte_valid, .byte_data,
    .irq_pend, .op_ready_q, .fetch_cnt_q, .dec_valid_q, .dec_mode_q, .op_len_q, .ea_q, .operand_q,
    .page0_q, .illegal_q, .wait_q, .halt_q, .sp_q);
  camd_fetch_model i_mem (.clk, .rstn, .op_valid, .op_ready_q, .fetch_cnt_q, .b0, .b1, .slow,
    .byte_valid, .byte_data);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one opcode through take, bytes and result pulse
  task automatic issue(input logic [7:0] op, input logic y, input logic [15:0] pc, input logic [7:0] ix,
                       input logic [7:0] a, input logic [7:0] c);
    int n;
    n = 0;
    while (op_ready_q !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    opcode   <= op;
    use_y    <= y;
    pc_next  <= pc;
    idx_val  <= ix;
    b0       <= a;
    b1       <= c;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (dec_valid_q !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_total++;
      wrap_up();
    end
  endtask : issue

  task automatic t_reset;
    chk(16'(sp_q), 16'h00ff);
    chk(16'(op_ready_q), 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_table;
    for (int m = 0; m < 17; m++) begin
      slow <= m[0];
      issue({m[4:0], 3'h0}, 1'b0, 16'h0100, 8'h10, 8'h20, 8'h30);
      chk(16'(dec_mode_q), 16'(m));
      chk(16'(op_len_q), 16'(len_pk[2*m +: 2]));
      chk(16'(fetch_cnt_q), 16'(cnt_pk[2*m +: 2]));
      chk(16'(illegal_q), 16'h0000);
    end
    issue(8'h20, 1'b1, 16'h0100, 8'h10, 8'h20, 8'h30);
    chk(16'(op_len_q), 16'h0001);
    chk(16'(fetch_cnt_q), 16'h0000);
    issue(8'h88, 1'b0, 16'h0100, 8'h10, 8'h20, 8'h30);
    chk(16'(illegal_q), 16'h0001);
    $display("test table done");
  endtask : t_table

  task automatic t_addr;
    issue(8'h10, 1'b0, 16'h0000, 8'h00, 8'h5a, 8'h00);
    chk(ea_q, 16'h005a);
    chk(16'(page0_q), 16'h0001);
    issue(8'h18, 1'b0, 16'h0000, 8'h00, 8'h12, 8'h34);
    chk(ea_q, 16'h1234);
    chk(16'(page0_q), 16'h0000);
    issue(8'h08, 1'b0, 16'h0000, 8'h00, 8'ha5, 8'h00);
    chk(16'(operand_q), 16'h00a5);
    issue(8'h28, 1'b0, 16'h0000, 8'hff, 8'hff, 8'h00);
    chk(ea_q, 16'h01fe);
    issue(8'h58, 1'b0, 16'h1000, 8'h00, 8'h80, 8'h00);
    chk(ea_q, 16'h0f80);
    issue(8'h58, 1'b0, 16'h1000, 8'h00, 8'h7f, 8'h00);
    chk(ea_q, 16'h107f);
    issue(8'h68, 1'b0, 16'h0000, 8'h00, 8'h3c, 8'h77);
    chk(ea_q, 16'h003c);
    chk(16'(operand_q), 16'h003c);
    issue(8'h78, 1'b0, 16'h2000, 8'h00, 8'h40, 8'hfe);
    chk(ea_q, 16'h1ffe);
    chk(16'(operand_q), 16'h00fe);
    issue(8'h1c, 1'b0, 16'h0000, 8'h00, 8'h12, 8'h34);
    chk(16'(illegal_q), 16'h0001);
    issue(8'h14, 1'b0, 16'h0000, 8'h00, 8'h12, 8'h00);
    chk(16'(illegal_q), 16'h0000);
    $display("test address done");
  endtask : t_addr

  task automatic t_power;
    issue(8'h03, 1'b0, 16'h0000, 8'h00, 8'h00, 8'h00);
    chk(16'(sp_q), 16'h00fe);
    issue(8'h04, 1'b0, 16'h0000, 8'h00, 8'h00, 8'h00);
    chk(16'(sp_q), 16'h00ff);
    for (int k = 1; k < 3; k++) begin
      issue({5'h00, 3'(k)}, 1'b0, 16'h0000, 8'h00, 8'h00, 8'h00);
      chk(16'(op_len_q), 16'h0000);
      repeat (4) @(posedge clk);
      // low-power state holds without a wake request
      chk(16'({wait_q, halt_q, op_ready_q}), (k == 1) ? 16'h0004 : 16'h0002);
      irq_pend <= 1'b1;
      repeat (3) @(posedge clk);
      irq_pend <= 1'b0;
      chk(16'({wait_q, halt_q, op_ready_q}), 16'h0001);
    end
    $display("test power done");
  endtask : t_power

  initial begin
    err_total = 0;
    n_checks  = 0;
    rstn      = 1'b0;
    op_valid  = 1'b0;
    opcode    = 8'h00;
    use_y     = 1'b0;
    pc_next   = 16'h0000;
    idx_val   = 8'h00;
    irq_pend  = 1'b0;
    slow      = 1'b0;
    b0        = 8'h00;
    b1        = 8'h00;
    repeat (8) @(posedge clk);
    t_reset();
    rstn <= 1'b1;
    t_table();
    t_addr();
    t_power();
    wrap_up();
  end
endmodule : camd_decoder_tb
`default_nettype wire
